// ==== logic/tag_service.sv ====
// Select and read-binary command handling between the reader side and the host side.
// Assumes a frame decoder delivers parsed commands and a transmitter takes response bytes.
`timescale 1ns/10ps
module tag_service #(
  parameter int depth = tag_service_pkg::buf_len
)(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic [15:0] cmd_file_id,
  input wire logic [15:0] cmd_offset,
  input wire logic [7:0] cmd_len,
  output logic cmd_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic general_irq_enable,
  input wire logic irq_flag_clear,
  input wire logic host_serviced,
  input wire logic file_exists,
  input wire logic custom_status_enable,
  input wire logic [15:0] custom_status_word,
  input wire logic [11:0] host_block_len,
  input wire logic buf_wr_en,
  input wire logic [11:0] buf_wr_idx,
  input wire logic [7:0] buf_wr_data,
  output logic host_irq_line,
  output logic irq_flag,
  output logic [1:0] command_field,
  output logic [15:0] selected_file_id,
  output logic [15:0] file_byte_offset,
  output logic [7:0] requested_block_len,
  output logic [11:0] buffer_start,
  output logic busy
);
  typedef enum {st_idle, st_shift, st_wait, st_data, st_sw1, st_sw2} phase_t;

  typedef struct packed {
    phase_t phase;
    logic flag;
    logic [1:0] cmd;
    logic is_read;
    logic [15:0] file_id;
    logic [15:0] offset;
    logic [7:0] len;
    logic [11:0] start;
    logic [15:0] cache_off;
    logic [11:0] cache_cnt;
    logic [11:0] idx;
    logic [11:0] shift_src;
    logic [11:0] shift_cnt;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] sent;
    logic [7:0] tx_byte;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [7:0] rd_data;
  logic [11:0] rd_idx;
  logic mv_en;
  logic [11:0] mv_idx;
  logic [11:0] skip;
  logic [16:0] req_end;
  logic [16:0] cache_end;
  logic hit;
  logic partial;

  tag_buffer #(.depth(depth), .aw(12)) u_buf (
    .clock(clock),
    .wr_en(mv_en | buf_wr_en),
    .wr_idx(mv_en ? mv_idx : buf_wr_idx),
    .wr_data(mv_en ? rd_data : buf_wr_data),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  // Cache window bookkeeping; cached bytes always begin at index zero
  always_comb
  begin
    req_end = {1'b0, cmd_offset} + {9'h000, cmd_len};
    cache_end = {1'b0, s_reg.cache_off} + {5'h00, s_reg.cache_cnt};
    hit = (cmd_offset >= s_reg.cache_off) && (req_end <= cache_end) && (s_reg.cache_cnt != 12'h000);
    partial = (cmd_offset >= s_reg.cache_off) && ({1'b0, cmd_offset} < cache_end);
    skip = 12'(cmd_offset - s_reg.cache_off);
  end

  always_comb
  begin
    s_next = s_reg;
    mv_en = 1'b0;
    mv_idx = s_reg.idx;
    rd_idx = s_reg.idx;
    if (irq_flag_clear)
    begin
      s_next.flag = 1'b0;
    end
    case (s_reg.phase)
      st_idle:
      begin
        if (cmd_valid)
        begin
          s_next.is_read = cmd_is_read;
          s_next.sent = 8'h00;
          if (!cmd_is_read)
          begin
            s_next.file_id = cmd_file_id;
            s_next.cmd = tag_service_pkg::cmd_select;
            s_next.flag = 1'b1;
            s_next.cache_cnt = 12'h000;
            s_next.phase = st_wait;
          end
          else
          begin
            // File id untouched on reads
            s_next.cmd = tag_service_pkg::cmd_read;
            s_next.offset = cmd_offset;
            s_next.len = cmd_len;
            if (hit)
            begin
              s_next.idx = skip;
              s_next.sw1 = tag_service_pkg::sw1_ok;
              s_next.sw2 = tag_service_pkg::sw2_ok;
              s_next.phase = (cmd_len == 8'h00) ? st_sw1 : st_data;
            end
            else if (partial && skip != 12'h000)
            begin
              s_next.shift_src = skip;
              s_next.shift_cnt = 12'(cache_end - {1'b0, cmd_offset});
              s_next.idx = 12'h000;
              s_next.phase = st_shift;
            end
            else
            begin
              s_next.start = partial ? s_reg.cache_cnt : 12'h000;
              if (!partial)
              begin
                s_next.cache_off = cmd_offset;
                s_next.cache_cnt = 12'h000;
              end
              s_next.flag = 1'b1;
              s_next.phase = st_wait;
            end
          end
        end
      end
      st_shift:
      begin
        // One byte per clock: read from the tail, write toward index zero
        rd_idx = 12'(s_reg.shift_src + s_reg.idx);
        mv_en = 1'b1;
        s_next.idx = 12'(s_reg.idx + 12'h001);
        if (12'(s_reg.idx + 12'h001) == s_reg.shift_cnt)
        begin
          s_next.cache_off = s_reg.offset;
          s_next.cache_cnt = s_reg.shift_cnt;
          s_next.start = s_reg.shift_cnt;
          s_next.flag = 1'b1;
          s_next.phase = st_wait;
        end
      end
      st_wait:
      begin
        // Blocks until the host reports servicing
        if (host_serviced)
        begin
          s_next.idx = 12'h000;
          if (custom_status_enable)
          begin
            s_next.sw1 = custom_status_word[15:8];
            s_next.sw2 = custom_status_word[7:0];
            s_next.phase = st_sw1;
          end
          else if (!s_reg.is_read)
          begin
            s_next.sw1 = file_exists ? tag_service_pkg::sw1_ok : tag_service_pkg::sw1_no_file;
            s_next.sw2 = file_exists ? tag_service_pkg::sw2_ok : tag_service_pkg::sw2_no_file;
            s_next.phase = st_sw1;
          end
          else
          begin
            // Host reports bytes written from buffer_start, not the total cached
            s_next.cache_cnt = (host_block_len > 12'(tag_service_pkg::buf_last)) ?
              12'(tag_service_pkg::buf_len) : 12'(s_reg.start + host_block_len);
            s_next.sw1 = tag_service_pkg::sw1_ok;
            s_next.sw2 = tag_service_pkg::sw2_ok;
            s_next.phase = (s_reg.len == 8'h00) ? st_sw1 : st_data;
          end
        end
      end
      st_data:
      begin
        if (tx_ready)
        begin
          s_next.idx = 12'(s_reg.idx + 12'h001);
          s_next.sent = 8'(s_reg.sent + 8'h01);
          if (8'(s_reg.sent + 8'h01) == s_reg.len)
          begin
            s_next.phase = st_sw1;
          end
        end
      end
      st_sw1:
      begin
        if (tx_ready)
        begin
          s_next.phase = st_sw2;
        end
      end
      st_sw2:
      begin
        if (tx_ready)
        begin
          s_next.phase = st_idle;
          s_next.cmd = tag_service_pkg::cmd_none;
        end
      end
      default:
      begin
        s_next.phase = st_idle;
      end
    endcase
    // Fetch the byte the next cycle shows, so the registered output never lags one index
    if (s_reg.phase != st_shift)
    begin
      rd_idx = s_next.idx;
    end
    // New event wins over a same-cycle clear
    if (s_reg.phase != st_wait && s_next.phase == st_wait)
    begin
      s_next.flag = 1'b1;
    end
    case (s_next.phase)
      st_data: s_next.tx_byte = rd_data;
      st_sw1: s_next.tx_byte = s_next.sw1;
      st_sw2: s_next.tx_byte = s_next.sw2;
      default: s_next.tx_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.phase <= st_idle;
      s_reg.file_id <= tag_service_pkg::file_id_reset;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  always_comb
  begin
    cmd_ready = (s_reg.phase == st_idle);
    tx_valid = (s_reg.phase == st_data) || (s_reg.phase == st_sw1) || (s_reg.phase == st_sw2);
    tx_last = (s_reg.phase == st_sw2);
    tx_data = s_reg.tx_byte;
    host_irq_line = s_reg.flag && general_irq_enable;
    irq_flag = s_reg.flag;
    command_field = s_reg.cmd;
    selected_file_id = s_reg.file_id;
    file_byte_offset = s_reg.offset;
    requested_block_len = s_reg.len;
    buffer_start = s_reg.start;
    busy = (s_reg.phase != st_idle);
  end
endmodule

// ==== logic/tag_service_pkg.sv ====
// Shared constants for the select/read service of a dynamic tag.
// Assumes a single 20 MHz clock domain and a synchronous active-low reset.
package tag_service_pkg;
  localparam int buf_len = 3000;
  localparam int buf_last = 2999;
  localparam int idx_w = 12;
  localparam logic [7:0] sw1_ok = 8'h90;
  localparam logic [7:0] sw2_ok = 8'h00;
  localparam logic [7:0] sw1_no_file = 8'h6a;
  localparam logic [7:0] sw2_no_file = 8'h82;
  localparam logic [1:0] cmd_none = 2'h0;
  localparam logic [1:0] cmd_select = 2'h1;
  localparam logic [1:0] cmd_read = 2'h2;
  localparam logic [15:0] file_id_reset = 16'h0000;
endpackage

// ==== logic/tag_buffer.sv ====
// Byte buffer of flip-flops with one write port and one combinational read port.
// Assumes the owner serialises host writes and internal compaction moves.
`timescale 1ns/10ps
module tag_buffer #(
  parameter int depth = 3000,
  parameter int aw = 12
)(
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [aw-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [aw-1:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem_reg [depth];

  // Storage holds no reset; stale bytes are never read past the valid count
  always_ff @(posedge clock)
  begin
    if (wr_en && (int'(wr_idx) < depth))
    begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  always_comb
  begin
    rd_data = (int'(rd_idx) < depth) ? mem_reg[rd_idx] : 8'h00;
  end
endmodule

// ==== tb/tag_service_chk.sv ====
// Port checker for the select/read service.
// Bound to tag_service by the bench; one clock, reset active low.
`timescale 1ns/10ps
module tag_service_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_is_read,
  input wire logic [15:0] cmd_file_id,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic host_serviced,
  input wire logic file_exists,
  input wire logic custom_status_enable,
  input wire logic [15:0] custom_status_word,
  input wire logic general_irq_enable,
  input wire logic host_irq_line,
  input wire logic irq_flag,
  input wire logic [1:0] command_field,
  input wire logic [15:0] selected_file_id
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence sel_taken;
    cmd_valid && cmd_ready && !cmd_is_read;
  endsequence
  sequence rd_taken;
    cmd_valid && cmd_ready && cmd_is_read;
  endsequence
  sequence sel_sw;
    command_field == 2'h1 && tx_valid && !custom_status_enable;
  endsequence
  a_sel_load_id: assert property (sel_taken |=> selected_file_id == $past(cmd_file_id))
    else $error("file id not loaded");
  a_sel_flag_up: assert property (sel_taken |=> irq_flag && command_field == 2'h1)
    else $error("select not flagged");
  a_irq_line_gate: assert property (host_irq_line == (irq_flag && general_irq_enable))
    else $error("irq line wrong");
  a_read_keep_id: assert property (rd_taken |=> $stable(selected_file_id))
    else $error("file id changed");
  a_flag_blocks_tx: assert property (irq_flag |-> !tx_valid && !cmd_ready)
    else $error("sent while flagged");
  a_serviced_answer: assert property (host_serviced && !irq_flag && !tx_valid && !cmd_ready |=> tx_valid)
    else $error("no answer after serviced");
  a_sel_sw_first: assert property (sel_sw ##0 !tx_last |-> tx_data == (file_exists ? 8'h90 : 8'h6a))
    else $error("select sw1 wrong");
  a_sel_sw_last: assert property (sel_sw ##0 tx_last |-> tx_data == (file_exists ? 8'h00 : 8'h82))
    else $error("select sw2 wrong");
  a_custom_only: assert property (custom_status_enable && tx_valid |->
    tx_data == (tx_last ? custom_status_word[7:0] : custom_status_word[15:8]))
    else $error("custom word wrong");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped");
endmodule

// ==== tb/host_model.sv ====
// Host stand-in: answers each interrupt, fills the buffer on reads, then signals serviced.
// Acts on the falling edge; extra and lag come from the bench.
`timescale 1ns/10ps
module host_model (
  input wire logic clock,
  input wire logic irq_flag,
  input wire logic [1:0] command_field,
  input wire logic [15:0] file_byte_offset,
  input wire logic [7:0] requested_block_len,
  input wire logic [11:0] buffer_start,
  input wire logic [11:0] extra,
  input wire logic [3:0] lag,
  output logic irq_flag_clear,
  output logic host_serviced,
  output logic [11:0] host_block_len,
  output logic buf_wr_en,
  output logic [11:0] buf_wr_idx,
  output logic [7:0] buf_wr_data
);
  int n;
  initial
  begin
    {irq_flag_clear, host_serviced, buf_wr_en, host_block_len, buf_wr_idx, buf_wr_data} = '0;
    forever
    begin
      @(negedge clock);
      if (irq_flag)
      begin
        repeat (lag) @(negedge clock);
        if (command_field == tag_service_pkg::cmd_read)
        begin
          // Caches past the request, but never beyond the last index
          n = int'(requested_block_len) + int'(extra);
          if (n > tag_service_pkg::buf_len - buffer_start)
            n = tag_service_pkg::buf_len - buffer_start;
          for (int i = 0; i < n; i++)
          begin
            buf_wr_en = 1'h1;
            buf_wr_idx = buffer_start + 12'(i);
            // Buffer index zero holds the file byte at the reported offset
            buf_wr_data = 8'((file_byte_offset + buffer_start + i) * 7 + 3);
            @(negedge clock);
          end
          buf_wr_en = 1'h0;
          buf_wr_data = ~buf_wr_data;
          host_block_len = 12'(n);
        end
        irq_flag_clear = 1'h1;
        @(negedge clock);
        irq_flag_clear = 1'h0;
        host_serviced = 1'h1;
        @(negedge clock);
        host_serviced = 1'h0;
      end
    end
  end
endmodule

// ==== tb/tag_service_bench.sv ====
// Self-checking bench for tag_service with the host stand-in on the register side.
// Reader commands and tx_ready come from here; inputs change on the falling edge.
`timescale 1ns/10ps
module tag_service_bench;
  logic clock = 1'h0, resetn = 1'h0, cmd_valid = 1'h0, cmd_is_read = 1'h0, tx_ready = 1'h0;
  logic general_irq_enable = 1'h1, file_exists = 1'h1, custom_status_enable = 1'h0;
  logic [15:0] cmd_file_id = 16'h0, cmd_offset = 16'h0, custom_status_word = 16'h0;
  logic [7:0] cmd_len = 8'h0;
  logic [11:0] extra = 12'h0;
  logic [3:0] lag = 4'h0;
  logic cmd_ready, tx_valid, tx_last, host_irq_line, irq_flag, busy, irq_flag_clear, host_serviced, buf_wr_en;
  logic [7:0] tx_data, requested_block_len, buf_wr_data, irq_len;
  logic [15:0] selected_file_id, file_byte_offset, sel_id, irq_off;
  logic [11:0] buffer_start, host_block_len, buf_wr_idx, irq_start;
  logic [1:0] command_field, irq_cmd;
  logic [7:0] got_q[$], exp_q[$];
  logic irq_seen, irq_busy;
  int err_count = 0, comparisons = 0, cycles = 0, seed = 21669;
  tag_service u_tag_service (.*);
  host_model u_host_model (.*);
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run(input logic rd, input logic [15:0] off, input logic [7:0] len, input int ei);
    got_q = {};
    exp_q = {};
    irq_seen = 1'h0;
    if (custom_status_enable)
      exp_q = {custom_status_word[15:8], custom_status_word[7:0]};
    else
    begin
      for (int k = 0; k < (rd ? len : 0); k++)
        exp_q.push_back(8'((off + k) * 7 + 3));
      exp_q.push_back(!rd && !file_exists ? 8'h6a : 8'h90);
      exp_q.push_back(!rd && !file_exists ? 8'h82 : 8'h00);
    end
    while (!cmd_ready) @(negedge clock);
    {cmd_valid, cmd_is_read, cmd_offset, cmd_len} = {1'h1, rd, off, len};
    cmd_file_id = 16'($random(seed));
    do
    begin
      @(negedge clock);
      cmd_valid = 1'h0;
      if (irq_flag && !irq_seen)
        {irq_seen, irq_start, irq_off, irq_len, irq_cmd, irq_busy} =
          {1'h1, buffer_start, file_byte_offset, requested_block_len, command_field, busy};
      tx_ready = 1'($random(seed));
      if (tx_valid && tx_ready)
        got_q.push_back(tx_data);
    end while (!(tx_valid && tx_ready && tx_last));
    @(negedge clock);
    tx_ready = 1'h0;
    chk("length", 16'(exp_q.size()), 16'(got_q.size()));
    foreach (exp_q[i]) chk("byte", exp_q[i], got_q[i]);
    if (ei >= 0) chk("interrupt", 16'(ei), 16'(irq_seen));
    if (irq_seen)
    begin
      chk("command field", 16'(rd ? tag_service_pkg::cmd_read : tag_service_pkg::cmd_select), 16'(irq_cmd));
      chk("busy", 16'h0001, 16'(irq_busy));
      if (rd)
      begin
        chk("file offset", off, irq_off);
        chk("block length", 16'(len), 16'(irq_len));
      end
    end
    chk("idle", 16'h0000, 16'(busy));
    $display("Test done: read %0d offset %0d length %0d", rd, off, len);
  endtask
  initial
  begin
    repeat (4) @(negedge clock);
    resetn = 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      file_exists = i != 1;
      custom_status_word = 16'($random(seed));
      custom_status_enable = i == 2;
      run(1'h0, 16'h0, 8'h0, 1);
      sel_id = cmd_file_id;
      chk("file id", sel_id, selected_file_id);
    end
    {custom_status_enable, file_exists, extra} = {1'h0, 1'h1, 12'h028};
    run(1'h1, 16'h0, 8'h14, 1);
    run(1'h1, 16'h14, 8'h14, 0);
    run(1'h1, 16'h32, 8'h14, 1);
    chk("buffer start", 16'h000a, 16'(irq_start));
    chk("file id", sel_id, selected_file_id);
    extra = 12'hbb8;
    run(1'h1, 16'h00c8, 8'h0a, 1);
    run(1'h1, 16'h0c76, 8'h0a, 0);
    custom_status_word = 16'($random(seed));
    custom_status_enable = 1'h1;
    run(1'h1, 16'h0fa0, 8'h08, 1);
    custom_status_enable = 1'h0;
    repeat (12)
    begin
      {extra, lag, general_irq_enable} = {12'($random(seed) & 63), 4'($random(seed)), 1'($random(seed))};
      run(1'h1, 16'($random(seed) & 511), 8'($random(seed) & 31), -1);
    end
    finish_test();
  end
endmodule
bind tag_service tag_service_chk u_tag_service_chk (.*);
